// ---- data_space_pkg.sv ----
// Constants shared by the data-space decoder and its program counter stack
`default_nettype none
package data_space_pkg;
   localparam int          PC_WIDTH       = 12;
   localparam int          STACK_LEVELS   = 6;
   localparam int          BLOCK_WIDTH    = 6;
   localparam int          READ_LATENCY   = 2;
   localparam logic [11:0] PC_RESET       = 12'h000;
   localparam logic [1:0]  WINDOW_TAG     = 2'h1;
   localparam logic [7:0]  OFS_INDEX_BASE = 8'h80;
   localparam logic [7:0]  OFS_PA_VALUE   = 8'hc0;
   localparam logic [7:0]  OFS_PB_VALUE   = 8'hc1;
   localparam logic [7:0]  OFS_PA_DIR     = 8'hc4;
   localparam logic [7:0]  OFS_PB_DIR     = 8'hc5;
   localparam logic [7:0]  OFS_INT_OPT    = 8'hc8;
   localparam logic [7:0]  OFS_WIN_SEL    = 8'hc9;
   localparam logic [7:0]  OFS_PA_OPT     = 8'hcc;
   localparam logic [7:0]  OFS_PB_OPT     = 8'hcd;
   localparam logic [7:0]  OFS_CONV_RES   = 8'hd0;
   localparam logic [7:0]  OFS_CONV_CTRL  = 8'hd1;
   localparam logic [7:0]  OFS_TIM_PRE    = 8'hd2;
   localparam logic [7:0]  OFS_TIM_CNT    = 8'hd3;
   localparam logic [7:0]  OFS_TIM_STAT   = 8'hd4;
   localparam logic [7:0]  OFS_WDG        = 8'hd8;
   localparam logic [7:0]  OFS_ACC        = 8'hff;
   localparam logic [7:0]  RST_PORT       = 8'h00;
   localparam logic [6:0]  RST_CONV_CTRL  = 7'h40;
   localparam logic [7:0]  RST_TIM_PRE    = 8'h7f;
   localparam logic [7:0]  RST_TIM_CNT    = 8'hff;
   localparam logic [7:0]  RST_TIM_STAT   = 8'h00;
   localparam logic [7:0]  RST_WDG        = 8'hfe;
   localparam logic [7:0]  READ_FILL      = 8'h00;
   localparam int          CONV_RO_BIT    = 7;
endpackage
`default_nettype wire

// ---- stack_if.sv ----
// Signals between the decoder top and the program counter stack
`default_nettype none
interface stack_if;
   logic        call;
   logic        ret;
   logic        jump;
   logic        step;
   logic [11:0] target;
   logic [11:0] pc;
   logic [2:0]  depth;
   modport core_side  (output call, output ret, output jump, output step,
                       output target, input pc, input depth);
   modport stack_side (input call, input ret, input jump, input step,
                       input target, output pc, output depth);
endinterface
`default_nettype wire

// ---- pc_stack.sv ----
// Program counter with its six-level return stack
`default_nettype none
module pc_stack #(
   parameter int LEVELS = data_space_pkg::STACK_LEVELS
) (
   input  wire logic     sys_clk,
   input  wire logic     rst,
   stack_if.stack_side   st
);
   logic [11:0] pc;
   logic [11:0] entry [LEVELS];
   logic [2:0]  depth;

   // Counter wraps at 4K: no address beyond the 12-bit reach
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pc <= data_space_pkg::PC_RESET;
      end else if (st.call || st.jump) begin
         pc <= st.target;
      end else if (st.ret) begin
         pc <= entry[0];
      end else if (st.step) begin
         pc <= pc + 12'h001;
      end
   end

   // Shift stack; a seventh call drops the deepest entry
   genvar i;
   generate
      for (i = 0; i < LEVELS; i++) begin : g_level
         // Neighbour indices clamped so the end levels never name a slot outside
         localparam int ABOVE = (i == 0) ? 0 : i - 1;
         localparam int BELOW = (i == LEVELS - 1) ? i : i + 1;
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               entry[i] <= 12'h000;
            end else if (st.call) begin
               entry[i] <= (i == 0) ? pc + 12'h001 : entry[ABOVE];
            end else if (st.ret) begin
               entry[i] <= (i == LEVELS - 1) ? 12'h000 : entry[BELOW];
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         depth <= 3'h0;
      end else if (st.call && depth != 3'(LEVELS)) begin
         depth <= depth + 3'h1;
      end else if (st.ret && !st.call && depth != 3'h0) begin
         depth <= depth - 3'h1;
      end
   end

   assign st.pc    = pc;
   assign st.depth = depth;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_call_then_ret;
      st.call && !st.ret ##1 st.ret && !st.call && !st.jump;
   endsequence
   property p_call_return;
      s_call_then_ret |=> pc == $past(pc, 2) + 12'h001;
   endproperty
   a_call_return: assert property (p_call_return)
      else $error("Return did not restore the address after the call");

   property p_call_target;
      st.call |=> pc == $past(st.target) && entry[0] == $past(pc) + 12'h001;
   endproperty
   a_call_target: assert property (p_call_target)
      else $error("Call did not load target and push return address");
endmodule
`default_nettype wire

// ---- data_space_map.sv ----
// Data-space decoder, register map and program memory read window
//
// Overview of operation
// - A 12-bit program counter reaches 4K bytes of program memory.
// - Six 12-bit stack entries hold return addresses beside the counter.
// - Reads at 40h..7Fh return 64 consecutive program memory bytes.
// - Program memory is 64 blocks of 64 bytes; block n starts n*64.
// - Writing a block number moves the window in 64-byte steps.
// - Window select keeps block in bits 5..0; bits 7..6 written zero.
// - Window select at C9h, write-only, left uninitialised by reset.
// - Port A and B value registers at C0h, C1h, reset 00h.
// - Value reads give stored bits for outputs, live pins for inputs.
// - Port direction registers at C4h, C5h, read-write, reset 00h.
// - Port option registers at CCh, CDh, read-write, reset 00h.
// - Converter result at D0h, read-only, no reset value.
// - Converter control at D1h, reset 40h, mixed read and write bits.
// - Timer prescaler at D2h, read-write, reset 7Fh.
// - Timer down-counter at D3h, read-write, reset FFh.
// - Timer status and control at D4h, read-write, reset 00h.
// - With readout protection set, external program reads are blocked.
`default_nettype none
module data_space_map (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       core_rd,
   input  wire logic       core_wr,
   input  wire logic [7:0] core_addr,
   input  wire logic [7:0] core_wdata,
   output logic [7:0]      core_rdata,
   output logic            core_rvalid,
   output logic [11:0]     mem_addr,
   output logic            mem_rd,
   input  wire logic [7:0] mem_rdata,
   input  wire logic       ext_rd,
   input  wire logic [11:0] ext_addr,
   input  wire logic       readout_protect,
   output logic            ext_ack,
   output logic            ext_denied,
   output logic [7:0]      ext_rdata,
   input  wire logic [7:0] port_a_pins,
   input  wire logic [7:0] port_b_pins,
   output logic [7:0]      port_a_out,
   output logic [7:0]      port_b_out,
   output logic [7:0]      port_a_oe,
   output logic [7:0]      port_b_oe,
   output logic [7:0]      port_a_opt,
   output logic [7:0]      port_b_opt,
   output logic [7:0]      int_options,
   input  wire logic [7:0] conv_result,
   input  wire logic       conv_done,
   output logic [6:0]      conv_ctrl,
   output logic [7:0]      timer_pre,
   output logic [7:0]      timer_cnt,
   output logic [7:0]      timer_stat,
   output logic [7:0]      wdg_count,
   input  wire logic       pc_call,
   input  wire logic       pc_ret,
   input  wire logic       pc_jump,
   input  wire logic       pc_step,
   input  wire logic [11:0] pc_target,
   output logic [11:0]     program_counter,
   output logic [2:0]      stack_depth
);
   stack_if st ();

   pc_stack u_stack (
      .sys_clk (sys_clk),
      .rst     (rst),
      .st      (st)
   );

   assign st.call   = pc_call;
   assign st.ret    = pc_ret;
   assign st.jump   = pc_jump;
   assign st.step   = pc_step;
   assign st.target = pc_target;
   assign program_counter = st.pc;
   assign stack_depth     = st.depth;

   logic [5:0]  window_block_number;
   logic [7:0]  index_reg [4];
   logic [7:0]  accumulator;
   logic [7:0]  port_a_value;
   logic [7:0]  port_b_value;
   logic        s1_rd;
   logic [7:0]  s1_addr;
   logic        ext_s1;
   logic        ext_s1_block;
   logic [7:0]  next_rdata;
   logic        win_hit;

   assign win_hit    = core_addr[7:6] == data_space_pkg::WINDOW_TAG;
   assign port_a_out = port_a_value;
   assign port_b_out = port_b_value;

   // Window select is never reset, so software must load it first
   always_ff @(posedge sys_clk) begin
      if (core_wr && core_addr == data_space_pkg::OFS_WIN_SEL) begin
         window_block_number <= core_wdata[5:0];
      end
   end

   // Core scratch registers carry no reset value
   always_ff @(posedge sys_clk) begin
      if (core_wr && core_addr[7:2] == data_space_pkg::OFS_INDEX_BASE[7:2]) begin
         index_reg[core_addr[1:0]] <= core_wdata;
      end
      if (core_wr && core_addr == data_space_pkg::OFS_ACC) begin
         accumulator <= core_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         port_a_value <= data_space_pkg::RST_PORT;
         port_b_value <= data_space_pkg::RST_PORT;
         port_a_oe    <= data_space_pkg::RST_PORT;
         port_b_oe    <= data_space_pkg::RST_PORT;
         port_a_opt   <= data_space_pkg::RST_PORT;
         port_b_opt   <= data_space_pkg::RST_PORT;
      end else if (core_wr) begin
         case (core_addr)
            data_space_pkg::OFS_PA_VALUE: port_a_value <= core_wdata;
            data_space_pkg::OFS_PB_VALUE: port_b_value <= core_wdata;
            data_space_pkg::OFS_PA_DIR:   port_a_oe    <= core_wdata;
            data_space_pkg::OFS_PB_DIR:   port_b_oe    <= core_wdata;
            data_space_pkg::OFS_PA_OPT:   port_a_opt   <= core_wdata;
            data_space_pkg::OFS_PB_OPT:   port_b_opt   <= core_wdata;
            default: ;
         endcase
      end
   end

   // Interrupt options are write-only and undefined until written
   always_ff @(posedge sys_clk) begin
      if (core_wr && core_addr == data_space_pkg::OFS_INT_OPT) begin
         int_options <= core_wdata;
      end
   end

   // Bit 7 of converter control is status from the converter, not stored
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         conv_ctrl  <= data_space_pkg::RST_CONV_CTRL;
         timer_pre  <= data_space_pkg::RST_TIM_PRE;
         timer_cnt  <= data_space_pkg::RST_TIM_CNT;
         timer_stat <= data_space_pkg::RST_TIM_STAT;
         wdg_count  <= data_space_pkg::RST_WDG;
      end else if (core_wr) begin
         case (core_addr)
            data_space_pkg::OFS_CONV_CTRL: conv_ctrl <= core_wdata[6:0];
            data_space_pkg::OFS_TIM_PRE:   timer_pre  <= core_wdata;
            data_space_pkg::OFS_TIM_CNT:   timer_cnt  <= core_wdata;
            data_space_pkg::OFS_TIM_STAT:  timer_stat <= core_wdata;
            data_space_pkg::OFS_WDG:       wdg_count  <= core_wdata;
            default: ;
         endcase
      end
   end

   // Read stage one: latch the address and start a program memory fetch.
   // The core has priority; an external read in the same cycle is dropped.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s1_rd        <= 1'b0;
         s1_addr      <= 8'h00;
         ext_s1       <= 1'b0;
         ext_s1_block <= 1'b0;
      end else begin
         s1_rd        <= core_rd;
         s1_addr      <= core_rd ? core_addr : s1_addr;
         ext_s1       <= ext_rd && !core_rd;
         ext_s1_block <= readout_protect;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mem_rd   <= 1'b0;
         mem_addr <= 12'h000;
      end else if (core_rd && win_hit) begin
         mem_rd   <= 1'b1;
         mem_addr <= {window_block_number, core_addr[5:0]};
      end else if (ext_rd && !core_rd && !readout_protect) begin
         mem_rd   <= 1'b1;
         mem_addr <= ext_addr;
      end else begin
         mem_rd   <= 1'b0;
      end
   end

   // Write-only and reserved locations read as fill with no side effect
   always_comb begin
      next_rdata = data_space_pkg::READ_FILL;
      if (s1_addr[7:6] == data_space_pkg::WINDOW_TAG) begin
         next_rdata = mem_rdata;
      end else if (s1_addr[7:2] == data_space_pkg::OFS_INDEX_BASE[7:2]) begin
         next_rdata = index_reg[s1_addr[1:0]];
      end else begin
         case (s1_addr)
            data_space_pkg::OFS_PA_VALUE:
               next_rdata = (port_a_oe & port_a_value) | (~port_a_oe & port_a_pins);
            data_space_pkg::OFS_PB_VALUE:
               next_rdata = (port_b_oe & port_b_value) | (~port_b_oe & port_b_pins);
            data_space_pkg::OFS_PA_DIR:    next_rdata = port_a_oe;
            data_space_pkg::OFS_PB_DIR:    next_rdata = port_b_oe;
            data_space_pkg::OFS_PA_OPT:    next_rdata = port_a_opt;
            data_space_pkg::OFS_PB_OPT:    next_rdata = port_b_opt;
            data_space_pkg::OFS_CONV_RES:  next_rdata = conv_result;
            data_space_pkg::OFS_CONV_CTRL: next_rdata = {conv_done, conv_ctrl};
            data_space_pkg::OFS_TIM_PRE:   next_rdata = timer_pre;
            data_space_pkg::OFS_TIM_CNT:   next_rdata = timer_cnt;
            data_space_pkg::OFS_TIM_STAT:  next_rdata = timer_stat;
            data_space_pkg::OFS_WDG:       next_rdata = wdg_count;
            data_space_pkg::OFS_ACC:       next_rdata = accumulator;
            default:                       next_rdata = data_space_pkg::READ_FILL;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         core_rvalid <= 1'b0;
         core_rdata  <= 8'h00;
      end else begin
         core_rvalid <= s1_rd;
         core_rdata  <= s1_rd ? next_rdata : core_rdata;
      end
   end

   // A blocked external read still answers, so a reader never hangs
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ext_ack    <= 1'b0;
         ext_denied <= 1'b0;
         ext_rdata  <= 8'h00;
      end else begin
         ext_ack    <= ext_s1;
         ext_denied <= ext_s1 && ext_s1_block;
         if (ext_s1) begin
            ext_rdata <= ext_s1_block ? data_space_pkg::READ_FILL : mem_rdata;
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   property p_window_addr;
      core_rd && win_hit |=> mem_rd
         && mem_addr == {$past(window_block_number), $past(core_addr[5:0])};
   endproperty
   a_window_addr: assert property (p_window_addr)
      else $error("Window fetch address is not block and offset");

   sequence s_window_read;
      core_rd && win_hit ##1 1'b1;
   endsequence
   property p_window_data;
      s_window_read |=> core_rvalid && core_rdata == $past(mem_rdata);
   endproperty
   a_window_data: assert property (p_window_data)
      else $error("Window read did not return program memory byte");

   // Reads may be back to back, so only the answer edge itself is pinned
   property p_read_latency;
      core_rd |-> ##2 core_rvalid;
   endproperty
   a_read_latency: assert property (p_read_latency)
      else $error("Read answer not two cycles after request");

   property p_port_read;
      s1_rd && s1_addr == data_space_pkg::OFS_PA_VALUE |=>
         core_rdata == (($past(port_a_oe) & $past(port_a_value))
                        | (~$past(port_a_oe) & $past(port_a_pins)));
   endproperty
   a_port_read: assert property (p_port_read)
      else $error("Port value read mixes pins and stored bits wrongly");

   property p_dir_write;
      core_wr && core_addr == data_space_pkg::OFS_PB_DIR |=>
         port_b_oe == $past(core_wdata) ##1 port_b_oe == $past(port_b_oe);
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("Direction write did not land or did not hold");

   property p_reset_values;
      $past(rst) |-> port_a_out == data_space_pkg::RST_PORT
         && timer_pre == data_space_pkg::RST_TIM_PRE
         && timer_cnt == data_space_pkg::RST_TIM_CNT
         && conv_ctrl == data_space_pkg::RST_CONV_CTRL;
   endproperty
   a_reset_values: assert property (@(posedge sys_clk) p_reset_values)
      else $error("Register reset value wrong");

   sequence s_blocked_ext;
      ext_rd && !core_rd && readout_protect;
   endsequence
   property p_protect;
      s_blocked_ext |=> !mem_rd ##1 ext_ack && ext_denied && ext_rdata == 8'h00;
   endproperty
   a_protect: assert property (p_protect)
      else $error("Protected program memory was read out");

   property p_select_write;
      core_wr && core_addr == data_space_pkg::OFS_WIN_SEL |=>
         window_block_number == $past(core_wdata[5:0]);
   endproperty
   a_select_write: assert property (p_select_write)
      else $error("Window select did not take the block number");

   property p_reserved_write;
      core_wr && core_addr == 8'hc2 |=> $stable(port_a_out) && $stable(port_b_oe)
         && $stable(timer_stat);
   endproperty
   a_reserved_write: assert property (p_reserved_write)
      else $error("Reserved write changed a register");
endmodule
`default_nettype wire

// ---- prog_mem_model.sv ----
// Program memory model answering the decoder's fetches without wait states
`default_nettype none
module prog_mem_model (
   input  wire logic        sys_clk,
   input  wire logic [11:0] mem_addr,
   input  wire logic        mem_rd,
   output logic [7:0]       mem_rdata
);
   timeunit 1ns;
   timeprecision 1ns;

   // Content ties every byte to its address so a wrong block or offset shows
   function automatic logic [7:0] rom_byte(input logic [11:0] a);
      return a[7:0] ^ {a[11:8], a[11:8]};
   endfunction

   // Outside a fetch the bus toggles, so a late sample never looks valid
   // Asynchronous read, the whole 4K space is decoded
   always_comb begin
      if (mem_rd === 1'b1) begin
         mem_rdata = rom_byte(mem_addr);
      end else begin
         mem_rdata = {8{sys_clk}} ^ 8'h5a;
      end
   end
endmodule
`default_nettype wire

// ---- data_space_map_rom_window_tb.sv ----
// Self-checking bench for the data-space decoder and read window
`default_nettype none
module data_space_map_rom_window_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [7:0] addr; logic done; logic [7:0] exp;} row_t;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        core_rd = 1'b0;
   logic        core_wr = 1'b0;
   logic [7:0]  core_addr = 8'h00;
   logic [7:0]  core_wdata = 8'h00;
   logic [7:0]  core_rdata;
   logic        core_rvalid;
   logic [11:0] mem_addr;
   logic        mem_rd;
   logic [7:0]  mem_rdata;
   logic        ext_rd = 1'b0;
   logic [11:0] ext_addr = 12'h000;
   logic        readout_protect = 1'b0;
   logic        ext_ack;
   logic        ext_denied;
   logic [7:0]  ext_rdata;
   logic [7:0]  port_a_pins = 8'h5a;
   logic [7:0]  port_b_pins = 8'ha5;
   logic [7:0]  port_a_out, port_b_out, port_a_oe, port_b_oe;
   logic [7:0]  port_a_opt, port_b_opt, int_options;
   logic [7:0]  conv_result = 8'h3c;
   logic        conv_done = 1'b0;
   logic [6:0]  conv_ctrl;
   logic [7:0]  timer_pre, timer_cnt, timer_stat, wdg_count;
   logic        pc_call = 1'b0;
   logic        pc_ret = 1'b0;
   logic        pc_jump = 1'b0;
   logic        pc_step = 1'b0;
   logic [11:0] pc_target = 12'h000;
   logic [11:0] program_counter;
   logic [2:0]  stack_depth;
   int          n_fail = 0;
   int          cmp_count = 0;
   row_t        rows [13] = '{'{8'hc0, 1'b0, 8'h5a}, '{8'hc1, 1'b0, 8'ha5},
      '{8'hc4, 1'b0, 8'h00}, '{8'hc5, 1'b0, 8'h00}, '{8'hcc, 1'b0, 8'h00},
      '{8'hcd, 1'b0, 8'h00}, '{8'hd0, 1'b0, 8'h3c}, '{8'hd1, 1'b1, 8'hc0},
      '{8'hd1, 1'b0, 8'h40}, '{8'hd2, 1'b0, 8'h7f}, '{8'hd3, 1'b0, 8'hff},
      '{8'hd4, 1'b0, 8'h00}, '{8'hd8, 1'b0, 8'hfe}};
   logic [7:0]  rw_addr [8] = '{8'hc4, 8'hc5, 8'hcc, 8'hcd, 8'hd2, 8'hd3, 8'hd4, 8'hd8};
   logic [5:0]  blocks [4] = '{6'h00, 6'h01, 6'h2a, 6'h3f};
   logic [5:0]  offsets [3] = '{6'h00, 6'h01, 6'h3f};

   data_space_map dut_u (.sys_clk, .rst, .core_rd, .core_wr, .core_addr, .core_wdata,
      .core_rdata, .core_rvalid, .mem_addr, .mem_rd, .mem_rdata, .ext_rd, .ext_addr,
      .readout_protect, .ext_ack, .ext_denied, .ext_rdata, .port_a_pins, .port_b_pins,
      .port_a_out, .port_b_out, .port_a_oe, .port_b_oe, .port_a_opt, .port_b_opt,
      .int_options, .conv_result, .conv_done, .conv_ctrl, .timer_pre, .timer_cnt,
      .timer_stat, .wdg_count, .pc_call, .pc_ret, .pc_jump, .pc_step, .pc_target,
      .program_counter, .stack_depth);
   prog_mem_model mem_u (.sys_clk, .mem_addr, .mem_rd, .mem_rdata);

   always #50 sys_clk = ~sys_clk;

   // Expected window bytes are rebuilt here from the address alone
   function automatic logic [7:0] rom_exp(input logic [11:0] a);
      return a[7:0] ^ {a[11:8], a[11:8]};
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      core_wr = 1'b1;
      core_addr = a;
      core_wdata = d;
      @(negedge sys_clk);
      core_wr = 1'b0;
   endtask

   // Read answer lands on the second edge after the request, checked in its one valid cycle
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge sys_clk);
      core_rd = 1'b1;
      core_addr = a;
      @(negedge sys_clk);
      core_rd = 1'b0;
      @(negedge sys_clk);
      chk(core_rvalid, 1'b1);
      chk(core_rdata, exp);
   endtask

   task automatic ext(input logic [11:0] a, input logic prot);
      @(negedge sys_clk);
      ext_rd = 1'b1;
      ext_addr = a;
      readout_protect = prot;
      @(negedge sys_clk);
      ext_rd = 1'b0;
      chk(mem_rd, !prot);
      @(negedge sys_clk);
      chk(ext_ack, 1'b1);
      chk(ext_denied, prot);
      chk(ext_rdata, prot ? 8'h00 : rom_exp(a));
   endtask

   // Operation bits are call, ret, jump, step
   task automatic pcop(input logic [3:0] op, input logic [11:0] t);
      @(negedge sys_clk);
      {pc_call, pc_ret, pc_jump, pc_step} = op;
      pc_target = t;
      @(negedge sys_clk);
      {pc_call, pc_ret, pc_jump, pc_step} = 4'h0;
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #500000;
      n_fail++;
      give_verdict();
   end

   initial begin
      repeat (8) @(negedge sys_clk);
      rst = 1'b0;
      chk({port_a_out, port_b_out}, 12'h000);
      chk({port_a_oe | port_b_oe | port_a_opt | port_b_opt}, 12'h000);
      chk({program_counter, stack_depth == 3'h0}, 13'h001);
      for (int i = 0; i < 13; i++) begin
         conv_done = rows[i].done;
         rd(rows[i].addr, rows[i].exp);
      end
      rd(8'hc8, 8'h00);
      $display("test reset_map done");
      // Window moves in whole blocks; the low six address bits pick the byte
      foreach (blocks[b]) begin
         wr(8'hc9, {2'b00, blocks[b]});
         foreach (offsets[o]) begin
            rd(8'h40 | {2'b00, offsets[o]}, rom_exp({blocks[b], offsets[o]}));
         end
      end
      rd(8'hc9, 8'h00);
      $display("test window done");
      // Every pin of both ports exists here, so no bit is held at reset
      foreach (rw_addr[i]) begin
         wr(rw_addr[i], rw_addr[i] ^ 8'h96);
         rd(rw_addr[i], rw_addr[i] ^ 8'h96);
      end
      chk({port_a_opt, port_b_opt}, 16'h5a5b);
      chk({timer_cnt, timer_stat}, 16'h4542);
      chk({wdg_count, port_b_oe}, 16'h4e53);
      // Port writes are whole bytes, never bit set or clear with input pins
      wr(8'hc4, 8'h0f);
      wr(8'hc0, 8'h33);
      port_a_pins = 8'hc6;
      chk(port_a_out, 8'h33);
      rd(8'hc0, (8'h33 & 8'h0f) | (8'hc6 & 8'hf0));
      wr(8'hc1, 8'hff);
      rd(8'hc1, (8'hff & 8'h53) | (port_b_pins & ~8'h53));
      wr(8'hd0, 8'h00);
      rd(8'hd0, 8'h3c);
      wr(8'hd1, 8'hff);
      chk(conv_ctrl, 7'h7f);
      conv_done = 1'b0;
      rd(8'hd1, 8'h7f);
      wr(8'hc2, 8'hff);
      rd(8'hc2, 8'h00);
      chk(timer_pre, 8'hd2 ^ 8'h96);
      wr(8'hc8, 8'h3d);
      chk(int_options, 8'h3d);
      $display("test access done");
      ext(12'h123, 1'b0);
      ext(12'hfc0, 1'b1);
      ext(12'hfff, 1'b0);
      $display("test readout done");
      pcop(4'h1, 12'h000);
      pcop(4'h8, 12'h100);
      chk({program_counter, 1'b0, stack_depth}, {12'h100, 4'h1});
      pcop(4'h8, 12'h200);
      pcop(4'h4, 12'h000);
      chk(program_counter, 12'h101);
      pcop(4'h4, 12'h000);
      chk({program_counter, 1'b0, stack_depth}, {12'h002, 4'h0});
      for (int i = 0; i < 7; i++) begin
         pcop(4'h8, 12'h300);
      end
      chk(stack_depth, 3'h6);
      pcop(4'h2, 12'hfff);
      pcop(4'h1, 12'h000);
      chk(program_counter, 12'h000);
      // Return straight after a call, on the full stack
      @(negedge sys_clk);
      pc_call = 1'b1;
      pc_target = 12'h3a5;
      @(negedge sys_clk);
      pc_call = 1'b0;
      pc_ret = 1'b1;
      @(negedge sys_clk);
      pc_ret = 1'b0;
      chk({program_counter, 1'b0, stack_depth}, {12'h001, 4'h5});
      $display("test stack done");
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      chk({port_a_oe, port_b_opt}, 16'h0000);
      chk({program_counter, 1'b0, stack_depth}, 16'h0000);
      rd(8'hd2, 8'h7f);
      rd(8'hd1, 8'h40);
      $display("test mid reset done");
      give_verdict();
   end
endmodule
`default_nettype wire
